//--- core/sbm_pkg.sv
// Constants, message carrier and state codes for the serial bus memory access block
package sbm_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Opcodes
   localparam logic [6:0] SBM_OP_LOCATION = 7'h07;
   localparam logic [6:0] SBM_OP_FRAMED = 7'h03;
   localparam logic [6:0] SBM_OP_SETUP = 7'h08;

   ////////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int SBM_SETUP_EXIT_BIT = 0;
   localparam int SBM_SETUP_WIDE_BIT = 4;
   localparam int SBM_SETUP_TARGET_IDX = 2;
   localparam int SBM_ADDR_HI_IDX = 0;
   localparam int SBM_ADDR_LO_IDX = 1;
   localparam int SBM_DATA_IDX = 2;
   localparam int SBM_COUNT_IDX = 2;

   ////////////////////////////////////////////////////////////////////////////////
   // Counts and sizes
   localparam logic [8:0] SBM_BLOCK_MAX = 9'h100;
   localparam logic [8:0] SBM_MSG_MAX = 9'h004;
   localparam logic [2:0] SBM_WIDE_READS = 3'h3;
   localparam logic [2:0] SBM_HEADER_BYTES = 3'h3;
   localparam logic [1:0] SBM_WIDE_STEP = 2'h2;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [15:0] SBM_ADDR_RST = 16'h0000;
   localparam logic [8:0] SBM_REM_RST = 9'h000;
   localparam logic [2:0] SBM_NLEFT_RST = 3'h0;
   localparam logic [1:0] SBM_BIDX_RST = 2'h0;
   localparam logic [7:0] SBM_BYTE_RST = 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // Message carrier, one bus message with up to four data bytes
   typedef struct packed {
      logic cont;
      logic [2:0] nbytes;
      logic [7:0] grp_dev;
      logic [6:0] opcode;
      logic br;
      logic [3:0][7:0] data;
   } sbm_msg_t;

   typedef enum logic [2:0] {
      SBM_IDLE = 3'b000,
      SBM_READ = 3'b001,
      SBM_SEND = 3'b011,
      SBM_WRITE = 3'b010,
      SBM_FWAIT = 3'b110
   } sbm_state_t;

endpackage

//--- core/sbm_core.sv
// Remote memory access command interpreter for the serial bus
`timescale 1ns/10ps
`default_nettype none

// What this block does
// R1 - Location messages with opcode 07 hex reach any byte of a 64K byte address space.
// R2 - The programmer selects the target with an access-setup message before location messages.
// R3 - Group and device bits of a location message are not used for routing.
// R4 - Standard location messages carry address high, address low, then the data byte.
// R5 - A broadcast location message (flag 0) stores its third byte at the 16-bit address.
// R6 - A request location message (flag 1) is answered by a broadcast with address and byte.
// R7 - The three-byte reply holds address plus 2, plus 1, then the addressed byte.
// R8 - The three-byte form is for reads only; writes always use the standard form.
// R9 - Framed block messages (opcode 03 hex) are kept only for legacy peers.
// R10 - A framed header gives start address and count, and a count of zero means 256.
// R11 - A framed block write sends a header, then data messages of up to 4 bytes each.
// R12 - A framed request is answered by a framed broadcast with address then the data bytes.
// R13 - A control bit of the access-setup message picks the one-byte or three-byte reply.
// R14 - Setup with exit bit set and no address match keeps the device quiet, replies included, until the next setup.
// R15 - A device not selected ignores location and framed messages entirely.
module sbm_core (
   // Clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic ce,
   // Own bus address
   input wire logic [7:0] own_addr,
   // Received messages
   input wire logic rx_valid,
   output logic rx_ready,
   input wire sbm_pkg::sbm_msg_t rx_msg,
   // Reply messages
   output logic tx_valid,
   input wire logic tx_ready,
   output sbm_pkg::sbm_msg_t tx_msg,
   // Local memory port
   output logic mem_req,
   output logic mem_we,
   output logic [15:0] mem_addr,
   output logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata,
   input wire logic mem_ack,
   // Status
   output logic selected,
   output logic tx_quiet
);
   import sbm_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // State
   sbm_state_t state;
   logic wide;
   logic framed;
   logic dir_down;
   logic [15:0] cur_addr;
   logic [8:0] rem;
   logic [2:0] nleft;
   logic [1:0] bidx;
   logic [3:0][7:0] buffer;
   logic [2:0] tx_nbytes;
   logic tx_cont;
   logic [6:0] tx_op;

   logic rx_fire;
   logic tx_fire;
   logic mem_done;
   logic is_setup;
   logic is_loc;
   logic is_frame_hdr;
   logic target_hit;
   logic [8:0] hdr_count;
   logic [8:0] next_rem;
   logic [2:0] next_chunk;
   logic [15:0] wide_start;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode
   assign rx_ready = (state == SBM_IDLE) || (state == SBM_FWAIT);
   assign rx_fire = rx_valid && rx_ready;
   assign tx_valid = (state == SBM_SEND);
   assign tx_fire = tx_valid && tx_ready;
   assign mem_req = (state == SBM_READ) || (state == SBM_WRITE);
   assign mem_we = (state == SBM_WRITE);
   assign mem_addr = cur_addr;
   assign mem_wdata = buffer[bidx];
   assign mem_done = mem_req && mem_ack;

   assign is_setup = !rx_msg.cont && (rx_msg.opcode == SBM_OP_SETUP);
   // Routing ignores grp_dev entirely; only the setup selection counts (see R3)
   assign is_loc = !rx_msg.cont && (rx_msg.opcode == SBM_OP_LOCATION) && selected; // see R1
   assign is_frame_hdr = !rx_msg.cont && (rx_msg.opcode == SBM_OP_FRAMED) && selected; // see R9
   assign target_hit = (rx_msg.data[SBM_SETUP_TARGET_IDX] == own_addr);
   // Zero count stands for a full block (see R10)
   assign hdr_count = (rx_msg.data[SBM_COUNT_IDX] == SBM_BYTE_RST) ? SBM_BLOCK_MAX :
                      {1'b0, rx_msg.data[SBM_COUNT_IDX]};
   assign next_chunk = (rem >= SBM_MSG_MAX) ? SBM_MSG_MAX[2:0] : rem[2:0];
   assign next_rem = rem - 9'h001;
   assign wide_start = {rx_msg.data[SBM_ADDR_HI_IDX], rx_msg.data[SBM_ADDR_LO_IDX]} +
                       {14'h0000, SBM_WIDE_STEP};

   ////////////////////////////////////////////////////////////////////////////////
   // Access-setup selection, reply format and quiet mode
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         selected <= 1'b0;
         wide <= 1'b0;
         tx_quiet <= 1'b0;
      end else if (ce && rx_fire && is_setup && state == SBM_IDLE) begin
         selected <= target_hit; // see R2
         wide <= target_hit && rx_msg.data[0][SBM_SETUP_WIDE_BIT]; // see R13
         tx_quiet <= rx_msg.data[0][SBM_SETUP_EXIT_BIT] && !target_hit; // see R14
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= SBM_IDLE;
         framed <= 1'b0;
         dir_down <= 1'b0;
         cur_addr <= SBM_ADDR_RST;
         rem <= SBM_REM_RST;
         nleft <= SBM_NLEFT_RST;
         bidx <= SBM_BIDX_RST;
         buffer <= '0;
         tx_nbytes <= SBM_NLEFT_RST;
         tx_cont <= 1'b0;
         tx_op <= SBM_OP_LOCATION;
      end else if (ce) begin
         unique case (state)
            SBM_IDLE: begin
               if (rx_fire && is_loc) begin
                  framed <= 1'b0;
                  tx_op <= SBM_OP_LOCATION;
                  tx_cont <= 1'b0;
                  tx_nbytes <= SBM_HEADER_BYTES;
                  if (!rx_msg.br) begin
                     // Store data byte at the 16-bit address (see R4) (see R5)
                     cur_addr <= {rx_msg.data[SBM_ADDR_HI_IDX], rx_msg.data[SBM_ADDR_LO_IDX]};
                     buffer[SBM_DATA_IDX] <= rx_msg.data[SBM_DATA_IDX];
                     bidx <= 2'(SBM_DATA_IDX);
                     nleft <= 3'h1;
                     state <= SBM_WRITE; // see R8
                  end else if (wide) begin
                     // Read plus 2, plus 1, then the byte itself (see R7)
                     cur_addr <= wide_start;
                     dir_down <= 1'b1;
                     bidx <= SBM_BIDX_RST;
                     nleft <= SBM_WIDE_READS;
                     state <= SBM_READ;
                  end else begin
                     // Reply echoes the address, then the byte read (see R6)
                     cur_addr <= {rx_msg.data[SBM_ADDR_HI_IDX], rx_msg.data[SBM_ADDR_LO_IDX]};
                     buffer[SBM_ADDR_HI_IDX] <= rx_msg.data[SBM_ADDR_HI_IDX];
                     buffer[SBM_ADDR_LO_IDX] <= rx_msg.data[SBM_ADDR_LO_IDX];
                     dir_down <= 1'b0;
                     bidx <= 2'(SBM_DATA_IDX);
                     nleft <= 3'h1;
                     state <= SBM_READ;
                  end
               end else if (rx_fire && is_frame_hdr) begin
                  framed <= 1'b1;
                  dir_down <= 1'b0;
                  tx_op <= SBM_OP_FRAMED;
                  cur_addr <= {rx_msg.data[SBM_ADDR_HI_IDX], rx_msg.data[SBM_ADDR_LO_IDX]};
                  rem <= hdr_count; // see R10
                  if (rx_msg.br) begin
                     // Header broadcast first, carrying address and count (see R12)
                     buffer <= rx_msg.data;
                     tx_nbytes <= SBM_HEADER_BYTES;
                     tx_cont <= 1'b0;
                     state <= SBM_SEND;
                  end else begin
                     state <= SBM_FWAIT; // see R11
                  end
               end
               // Anything else, or a location or framed message while not selected, is dropped (see R15)
            end
            SBM_FWAIT: begin
               if (!selected) begin
                  state <= SBM_IDLE;
               end else if (rx_fire && rx_msg.cont && rx_msg.nbytes != 3'h0) begin
                  buffer <= rx_msg.data;
                  bidx <= SBM_BIDX_RST;
                  nleft <= ({6'h00, rx_msg.nbytes} < rem) ? rx_msg.nbytes : rem[2:0];
                  state <= SBM_WRITE;
               end else if (rx_fire) begin
                  state <= SBM_IDLE;
               end
            end
            SBM_WRITE: begin
               if (mem_done) begin
                  cur_addr <= cur_addr + 16'h0001;
                  bidx <= bidx + 2'h1;
                  nleft <= nleft - 3'h1;
                  if (framed) begin
                     rem <= next_rem;
                  end
                  if (nleft == 3'h1) begin
                     state <= (framed && next_rem != SBM_REM_RST) ? SBM_FWAIT : SBM_IDLE;
                  end
               end
            end
            SBM_READ: begin
               if (mem_done) begin
                  buffer[bidx] <= mem_rdata;
                  bidx <= bidx + 2'h1;
                  nleft <= nleft - 3'h1;
                  cur_addr <= dir_down ? cur_addr - 16'h0001 : cur_addr + 16'h0001;
                  if (framed) begin
                     rem <= next_rem;
                  end
                  if (nleft == 3'h1) begin
                     if (framed) begin
                        tx_nbytes <= bidx + 3'h1;
                        tx_cont <= 1'b1;
                     end
                     state <= SBM_SEND;
                  end
               end
            end
            SBM_SEND: begin
               if (tx_fire) begin
                  if (framed && rem != SBM_REM_RST) begin
                     bidx <= SBM_BIDX_RST;
                     nleft <= next_chunk;
                     buffer <= '0;
                     state <= SBM_READ; // see R12
                  end else begin
                     state <= SBM_IDLE;
                  end
               end
            end
            default: begin
               state <= SBM_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Reply message, always a broadcast from this device
   always_comb begin
      tx_msg = '0;
      tx_msg.cont = tx_cont;
      tx_msg.nbytes = tx_nbytes;
      tx_msg.grp_dev = own_addr;
      tx_msg.opcode = tx_op;
      tx_msg.br = 1'b0;
      tx_msg.data = buffer;
   end

endmodule // sbm_core

`default_nettype wire

//--- verif/sbm_mem_model.sv
// Local memory model that answers the block's memory port
`timescale 1ns/10ps
`default_nettype none
module sbm_mem_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Memory port
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata,
   output logic mem_ack,
   // Wait cycles before each acknowledge
   input wire logic [1:0] dly
);
   logic [7:0] mem [0:65535];
   logic [1:0] wait_cnt;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) wait_cnt <= 2'h0;
      else wait_cnt <= (mem_req && !mem_ack) ? wait_cnt + 2'h1 : 2'h0;
   end
   assign mem_ack = mem_req && wait_cnt >= dly;
   // Whole 64K byte space
   always_ff @(posedge sys_clk) begin
      if (mem_req && mem_ack && mem_we) mem[mem_addr] <= mem_wdata;
   end
   // Data only good with the acknowledge
   assign mem_rdata = mem_ack ? mem[mem_addr] : ~mem[mem_addr];
endmodule // sbm_mem_model
`default_nettype wire

//--- verif/sbm_assertions.sv
// Port checker for the serial bus memory access block
`timescale 1ns/10ps
`default_nettype none
module sbm_chk (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Watched ports
   input wire logic ce,
   input wire logic rx_valid,
   input wire logic rx_ready,
   input wire sbm_pkg::sbm_msg_t rx_msg,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire sbm_pkg::sbm_msg_t tx_msg,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic selected
);
   import sbm_pkg::*;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   logic take;
   logic blk;
   logic [15:0] req_addr;
   assign take = ce && rx_valid && rx_ready;
   assign req_addr = {rx_msg.data[0], rx_msg.data[1]};
   // Framed write pending, location checks skipped
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) blk <= 1'b0;
      else if (take && !rx_msg.cont) blk <= rx_msg.opcode == SBM_OP_FRAMED && !rx_msg.br;
   end
   ////////////////////////////////////////
   sequence loc_take(bit rd);
      take && selected && !blk && !rx_msg.cont && rx_msg.opcode == SBM_OP_LOCATION
         && rx_msg.br == rd;
   endsequence
   chk_read_start: assert property (loc_take(1'b1) |=> mem_req && !mem_we
      && (mem_addr == $past(req_addr) || mem_addr == $past(req_addr) + 16'h0002))
      else $error("read began at a wrong address");
   chk_read_reply: assert property (loc_take(1'b1) |-> ##[2:60] tx_valid)
      else $error("read got no reply");
   chk_write_store: assert property (loc_take(1'b0) |=> mem_req && mem_we
      && mem_addr == $past(req_addr) && mem_wdata == $past(rx_msg.data[2]))
      else $error("write went to a wrong place");
   chk_unsel_drop: assert property (take && !selected && (rx_msg.opcode == SBM_OP_LOCATION
      || rx_msg.opcode == SBM_OP_FRAMED) |=> !mem_req && !tx_valid)
      else $error("unselected message acted on");
   chk_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
      else $error("memory request dropped");
   chk_tx_hold: assert property (tx_valid && !(ce && tx_ready) |=> tx_valid && $stable(tx_msg))
      else $error("reply changed while waiting");
   chk_busy_block: assert property (mem_req || tx_valid |-> !rx_ready)
      else $error("message taken while busy");
   chk_reply_kind: assert property (tx_valid |-> !tx_msg.br && (tx_msg.opcode == SBM_OP_LOCATION
      || tx_msg.opcode == SBM_OP_FRAMED))
      else $error("reply is not a broadcast");
   chk_mem_sel: assert property (mem_req |-> selected)
      else $error("memory access while unselected");
endmodule // sbm_chk
bind sbm_core sbm_chk chk (.sys_clk, .rst_n, .ce, .rx_valid, .rx_ready, .rx_msg, .tx_valid,
   .tx_ready, .tx_msg, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .selected);
`default_nettype wire

//--- verif/tb_sbm_core.sv
// Testbench of the serial bus memory access block
`timescale 1ns/10ps
`default_nettype none
module tb_sbm_core;
   import sbm_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic [7:0] own_addr = 8'h5a;
   logic rx_valid = 1'b0;
   logic tx_ready = 1'b0;
   logic [1:0] dly = 2'h0;
   sbm_msg_t rx_msg = '0;
   sbm_msg_t tx_msg;
   logic rx_ready, tx_valid, mem_req, mem_we, mem_ack, selected, tx_quiet;
   logic [15:0] mem_addr;
   logic [7:0] mem_wdata, mem_rdata;
   logic [7:0] mirror [0:65535];
   sbm_msg_t exp_q [$];
   int err_count = 0;
   int cmp_count = 0;
   int cycles = 0;
   int seed = 32'h48dd;
   always #20 sys_clk = ~sys_clk;
   sbm_core dut (.sys_clk, .rst_n, .ce, .own_addr, .rx_valid, .rx_ready, .rx_msg, .tx_valid,
      .tx_ready, .tx_msg, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack,
      .selected, .tx_quiet);
   sbm_mem_model mem (.sys_clk, .rst_n, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
      .mem_ack, .dly);
   ////////////////////////////////////////
   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check_val(string what, logic [31:0] e, logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic check_msg(sbm_msg_t e, sbm_msg_t g);
      check_val("reply head", 32'({e.cont, e.nbytes, e.grp_dev, e.opcode, e.br}),
         32'({g.cont, g.nbytes, g.grp_dev, g.opcode, g.br}));
      for (int i = 0; i < 4; i++) if (i < e.nbytes) check_val("reply byte", 32'(e.data[i]),
         32'(g.data[i]));
   endtask
   task automatic send(logic [6:0] op, logic br, logic cont, logic [2:0] nb, logic [31:0] d);
      @(negedge sys_clk);
      dly = 2'($random(seed));
      rx_msg = '{cont, nb, 8'($random(seed)), op, br, d};
      rx_valid = 1'b1;
      while (rx_ready !== 1'b1) @(negedge sys_clk);
      @(negedge sys_clk);
      rx_valid = 1'b0;
   endtask
   task automatic setup(logic [7:0] ctl, logic [7:0] tgt);
      send(SBM_OP_SETUP, 1'b0, 1'b0, 3'h3, {8'h00, tgt, 8'h00, ctl});
   endtask
   task automatic wr(logic [15:0] a, logic [7:0] v);
      send(SBM_OP_LOCATION, 1'b0, 1'b0, 3'h3, {8'h00, v, a[7:0], a[15:8]});
      mirror[a] = v;
   endtask
   task automatic rd(logic [15:0] a, logic wide);
      sbm_msg_t e;
      e = '{1'b0, 3'h3, own_addr, SBM_OP_LOCATION, 1'b0, {8'h00, mirror[a], a[7:0], a[15:8]}};
      if (wide) e.data[2:0] = {mirror[a], mirror[a + 16'h1], mirror[a + 16'h2]};
      exp_q.push_back(e);
      send(SBM_OP_LOCATION, 1'b1, 1'b0, 3'h3, {16'h0000, a[7:0], a[15:8]});
   endtask
   task automatic fwr(logic [15:0] a, logic [8:0] n);
      logic [31:0] d;
      send(SBM_OP_FRAMED, 1'b0, 1'b0, 3'h3, {8'h00, n[7:0], a[7:0], a[15:8]});
      for (int i = 0; i < n; i += 4) begin
         d = $random(seed);
         for (int k = 0; k < 4; k++) if (i + k < n) mirror[a + 16'(i + k)] = d[8*k +: 8];
         send(SBM_OP_FRAMED, 1'b0, 1'b1, (n - i > 4) ? 3'h4 : 3'(n - i), d);
      end
   endtask
   task automatic frd(logic [15:0] a, logic [8:0] n);
      sbm_msg_t e;
      e = '{1'b0, 3'h3, own_addr, SBM_OP_FRAMED, 1'b0, {8'h00, n[7:0], a[7:0], a[15:8]}};
      exp_q.push_back(e);
      send(SBM_OP_FRAMED, 1'b1, 1'b0, 3'h3, e.data);
      for (int i = 0; i < n; i += 4) begin
         e.cont = 1'b1;
         e.nbytes = (n - i > 4) ? 3'h4 : 3'(n - i);
         for (int k = 0; k < 4; k++) e.data[k] = mirror[a + 16'(i + k)];
         exp_q.push_back(e);
      end
      wait (exp_q.size() == 0);
   endtask
   ////////////////////////////////////////
   always @(negedge sys_clk) begin
      tx_ready = 1'($random(seed));
      if (rst_n && tx_valid && tx_ready) begin
         if (exp_q.size() == 0) check_val("spare reply", 32'h0000_0000, 32'h0000_0001);
         else check_msg(exp_q.pop_front(), tx_msg);
      end
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         report_and_stop;
      end
   end
   initial begin
      logic [15:0] base [6];
      repeat (10) @(negedge sys_clk);
      rst_n = 1'b1;
      send(SBM_OP_LOCATION, 1'b1, 1'b0, 3'h3, 32'h0000_1234);
      send(SBM_OP_FRAMED, 1'b1, 1'b0, 3'h3, 32'h0004_1234);
      setup(8'h00, own_addr);
      check_val("selected", 32'h0000_0001, 32'(selected));
      // Clock enable low: a setup on the bus must leave selection untouched
      ce = 1'b0;
      setup(8'h01, ~own_addr);
      check_val("frozen", 32'h0000_0002, 32'({selected, tx_quiet}));
      ce = 1'b1;
      foreach (base[i]) begin
         base[i] = (i == 0) ? 16'hfffd : 16'($random(seed));
         for (int k = 0; k < 3; k++) wr(base[i] + 16'(k), 8'($random(seed)));
      end
      foreach (base[i]) rd(base[i], 1'b0);
      setup(8'h10, own_addr);
      foreach (base[i]) wr(base[i], 8'($random(seed)));
      foreach (base[i]) rd(base[i], 1'b1);
      setup(8'h01, ~own_addr);
      check_val("quiet", 32'h0000_0001, 32'(tx_quiet));
      send(SBM_OP_LOCATION, 1'b1, 1'b0, 3'h3, 32'h0000_1234);
      setup(8'h00, ~own_addr);
      check_val("quiet", 32'h0000_0000, 32'(tx_quiet));
      setup(8'h00, own_addr);
      for (int i = 0; i < 2; i++) begin
         fwr(16'h4000 + 16'(i * 16'h1000), i ? 9'h100 : 9'h005);
         frd(16'h4000 + 16'(i * 16'h1000), i ? 9'h100 : 9'h005);
      end
      repeat (4) @(negedge sys_clk);
      rst_n = 1'b0;
      @(negedge sys_clk);
      check_val("selected", 32'h0000_0000, 32'(selected));
      rst_n = 1'b1;
      report_and_stop;
   end
endmodule // tb_sbm_core
`default_nettype wire
